/* hw/can_sic_defs.svh */
// timing constants for the ringing-suppression transceiver and its controller
// assumes a 125 MHz reference clock on both ends
`ifndef CAN_SIC_DEFS_SVH
`define CAN_SIC_DEFS_SVH

`define CAN_CLK_NS            8
`define CAN_DTO_NS            1200000
`define CAN_DTO_CYCLES        (`CAN_DTO_NS / `CAN_CLK_NS)
`define CAN_PAS_REC_MIN_NS    420
`define CAN_PAS_REC_MAX_NS    530
`define CAN_ACT_REC_CYCLES    ((`CAN_PAS_REC_MIN_NS + `CAN_CLK_NS - 1) / `CAN_CLK_NS)
`define CAN_WAKE_FILT_CYCLES  63
`define CAN_MAX_DOM_BITS      11
`define CAN_BIT_CYCLES        16

`endif

/* hw/can_sic_pkg.sv */
// types shared by both ends of the transceiver logic link
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package can_sic_pkg;

   typedef enum logic {
      SIC_PASSIVE = 1'b0,
      SIC_ACTIVE  = 1'b1
   } sic_phase_e;

   typedef enum logic [2:0] {
      WAKE_IDLE = 3'h0,
      WAKE_DOM1 = 3'h1,
      WAKE_REC1 = 3'h3,
      WAKE_DOM2 = 3'h2,
      WAKE_DONE = 3'h6
   } wake_state_e;

endpackage : can_sic_pkg
`default_nettype wire

/* hw/can_sic_if.sv */
// logic-side pins between protocol controller and transceiver
// assumes both ends share REF_CLK; rxd level is meaningful only while rxd_oe is high
`default_nettype none
interface can_sic_if;
   logic txd;
   logic stb;
   logic rxd;
   logic rxd_oe;

   modport ctrl (output txd, output stb, input rxd, input rxd_oe);
   modport xcvr (input txd, input stb, output rxd, output rxd_oe);
endinterface : can_sic_if
`default_nettype wire

/* hw/can_sic_xcvr.sv */
// transceiver digital control: bus state mapping, dominant timeout, ringing suppression, standby wake
// assumes txd/stb and BUS_DOMINANT synchronous to REF_CLK; bus drivers are analog cells outside
//
// Notes on behaviour
// - txd low drives dominant; dominant gives rxd low
// - txd high leaves recessive; recessive gives rxd high
// - dominant timeout works only in normal mode
// - each txd falling edge starts timeout measurement
// - no rising edge in time disables driver
// - txd high re-enables driver, clears fault
// - receiver keeps mirroring bus during fault
// - controller bit rate keeps eleven dominants short
// - drive recessive low impedance after rising edge; the code skips this after a rising edge that ends a timeout fault
// - then passive recessive, driver high impedance
// - up to 8Mbps, rate independent behaviour
// - standby biases bus lines weakly to ground
// - wake in standby drives rxd low
// - controller returns to normal after wake
// - mode select may be tied to ground
// - rxd undriven until logic supply present
// - mode select high standby, low normal
// - standby rxd stays high until wake
// - passive phase starts 420 to 530 ns
// - wake is dom, rec, dom, rec filtered
`include "can_sic_defs.svh"
`default_nettype none
module can_sic_xcvr
   import can_sic_pkg::*;
#(
   parameter int DTO_CYCLES       = `CAN_DTO_CYCLES,
   parameter int ACT_REC_CYCLES   = `CAN_ACT_REC_CYCLES,
   parameter int WAKE_FILT_CYCLES = `CAN_WAKE_FILT_CYCLES
) (
   input  wire logic   REF_CLK,
   input  wire logic   RST_N,
   can_sic_if.xcvr     PINS,
   input  wire logic   LOGIC_SUPPLY_OK,
   input  wire logic   BUS_DOMINANT,
   output var  logic   DRIVE_DOMINANT,
   output var  logic   DRIVE_ACTIVE_REC,
   output var  logic   BIAS_MID,
   output var  logic   BIAS_GND,
   output var  logic   DTO_FAULT,
   output var  logic   WAKE_FLAG
);

   localparam int DTO_W  = $clog2(DTO_CYCLES + 1);
   localparam int ACT_W  = $clog2(ACT_REC_CYCLES + 1);
   localparam int FILT_W = $clog2(WAKE_FILT_CYCLES + 1);

   typedef struct packed {
      logic              txd_prev;
      logic              dto_run;
      logic [DTO_W-1:0]  dto_cnt;
      logic              dto_fault;
      sic_phase_e        sic;
      logic [ACT_W-1:0]  act_cnt;
      wake_state_e       wake;
      logic              bus_last;
      logic [FILT_W-1:0] run_cnt;
      logic [FILT_W-1:0] hold_cnt;
      logic              rxd_latched;
      logic              rxd;
      logic              rxd_oe;
      logic              drv_dom;
      logic              drv_act;
      logic              bias_mid;
      logic              bias_gnd;
   } xcvr_s;

   xcvr_s s;
   xcvr_s next_s;

   logic normal;
   logic txd_fall;
   logic txd_rise;
   logic filt_hit;
   logic filt_dom;
   logic filt_rec;

   always_comb begin
      next_s   = s;
      normal   = ~PINS.stb;
      txd_fall = s.txd_prev & ~PINS.txd;
      txd_rise = ~s.txd_prev & PINS.txd;
      next_s.txd_prev = PINS.txd;

      // dominant timeout supervisor
      if (!normal) begin
         next_s.dto_run   = 1'b0;
         next_s.dto_cnt   = '0;
         next_s.dto_fault = 1'b0;
      end else if (txd_fall) begin
         next_s.dto_run = 1'b1;
         next_s.dto_cnt = '0;
      end else if (PINS.txd) begin
         next_s.dto_run   = 1'b0;
         next_s.dto_fault = 1'b0;
      end else if (s.dto_run) begin
         if (s.dto_cnt == DTO_W'(DTO_CYCLES - 1)) begin
            next_s.dto_run   = 1'b0;
            next_s.dto_fault = 1'b1;
         end else begin
            next_s.dto_cnt = s.dto_cnt + DTO_W'(1);
         end
      end

      // ringing suppression after each rising edge that does not end a timeout fault, independent of bit rate
      if (!normal) begin
         next_s.sic     = SIC_PASSIVE;
         next_s.act_cnt = '0;
      end else if (txd_rise && !s.dto_fault) begin
         next_s.sic     = SIC_ACTIVE;
         next_s.act_cnt = ACT_W'(ACT_REC_CYCLES - 1);
      end else if (s.sic == SIC_ACTIVE) begin
         if (!PINS.txd || s.act_cnt == '0) begin
            next_s.sic = SIC_PASSIVE;
         end else begin
            next_s.act_cnt = s.act_cnt - ACT_W'(1);
         end
      end

      // bus drive and bias, registered
      next_s.drv_dom  = normal & ~PINS.txd & ~next_s.dto_fault;
      next_s.drv_act  = normal & PINS.txd & (next_s.sic == SIC_ACTIVE);
      next_s.bias_mid = normal;
      next_s.bias_gnd = ~normal;

      // wake pattern filter in standby
      next_s.bus_last = BUS_DOMINANT;
      filt_hit = 1'b0;
      if (BUS_DOMINANT != s.bus_last) begin
         next_s.run_cnt = '0;
      end else if (s.run_cnt != FILT_W'(WAKE_FILT_CYCLES - 1)) begin
         next_s.run_cnt = s.run_cnt + FILT_W'(1);
         filt_hit = (s.run_cnt == FILT_W'(WAKE_FILT_CYCLES - 2));
      end
      filt_dom = filt_hit & BUS_DOMINANT;
      filt_rec = filt_hit & ~BUS_DOMINANT;
      if (s.hold_cnt != '0) begin
         next_s.hold_cnt = s.hold_cnt - FILT_W'(1);
      end

      if (normal) begin
         next_s.wake        = WAKE_IDLE;
         next_s.hold_cnt    = '0;
         next_s.rxd_latched = 1'b0;
      end else begin
         unique case (s.wake)
            WAKE_IDLE: begin
               if (filt_dom) begin
                  next_s.wake = WAKE_DOM1;
               end
            end
            WAKE_DOM1: begin
               if (filt_rec) begin
                  next_s.wake = WAKE_REC1;
               end
            end
            WAKE_REC1: begin
               if (filt_dom) begin
                  next_s.wake = WAKE_DOM2;
               end
            end
            WAKE_DOM2: begin
               if (filt_rec) begin
                  next_s.wake     = WAKE_DONE;
                  next_s.hold_cnt = FILT_W'(WAKE_FILT_CYCLES);
               end
            end
            WAKE_DONE: begin
               if (BUS_DOMINANT) begin
                  next_s.rxd_latched = 1'b1;
               end
            end
            default: begin
               next_s.wake = WAKE_IDLE;
            end
         endcase
      end

      // receive pin
      if (normal) begin
         next_s.rxd = ~BUS_DOMINANT;
      end else begin
         next_s.rxd = ~((next_s.hold_cnt != '0) | next_s.rxd_latched);
      end
      next_s.rxd_oe = LOGIC_SUPPLY_OK;
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s          <= '0;
         s.txd_prev <= 1'b1;
         s.wake     <= WAKE_IDLE;
         s.sic      <= SIC_PASSIVE;
         s.rxd      <= 1'b1;
         s.bias_gnd <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign PINS.rxd         = s.rxd;
   assign PINS.rxd_oe      = s.rxd_oe;
   assign DRIVE_DOMINANT   = s.drv_dom;
   assign DRIVE_ACTIVE_REC = s.drv_act;
   assign BIAS_MID         = s.bias_mid;
   assign BIAS_GND         = s.bias_gnd;
   assign DTO_FAULT        = s.dto_fault;
   assign WAKE_FLAG        = (s.wake == WAKE_DONE);

endmodule : can_sic_xcvr
`default_nettype wire

/* hw/can_sic_ctrl.sv */
// protocol controller end: bit timing of txd, mode select and wake handling
// assumes the transceiver end on the same REF_CLK
`include "can_sic_defs.svh"
`default_nettype none
module can_sic_ctrl
   import can_sic_pkg::*;
#(
   parameter int BIT_CYCLES = `CAN_BIT_CYCLES,
   parameter int DTO_CYCLES = `CAN_DTO_CYCLES
) (
   input  wire logic   REF_CLK,
   input  wire logic   RST_N,
   can_sic_if.ctrl     PINS,
   input  wire logic   TX_BIT,
   input  wire logic   STANDBY_REQ,
   output var  logic   BIT_STROBE,
   output var  logic   RX_BIT,
   output var  logic   WAKE_SEEN
);

   // eleven dominant bits must end before the timeout
   localparam int MAX_BIT = DTO_CYCLES / `CAN_MAX_DOM_BITS - 1;
   localparam int BIT_USED = (BIT_CYCLES < MAX_BIT) ? BIT_CYCLES : MAX_BIT;
   localparam int BIT_W = $clog2(BIT_USED + 1);

   typedef struct packed {
      logic [BIT_W-1:0] bit_cnt;
      logic             strobe;
      logic             txd;
      logic             stb;
      logic             wake;
      logic             rx;
   } ctrl_s;

   ctrl_s s;
   ctrl_s next_s;

   always_comb begin
      next_s        = s;
      next_s.strobe = 1'b0;
      if (s.bit_cnt == BIT_W'(BIT_USED - 1)) begin
         next_s.bit_cnt = '0;
         next_s.strobe  = 1'b1;
         next_s.txd     = TX_BIT | s.stb;
      end else begin
         next_s.bit_cnt = s.bit_cnt + BIT_W'(1);
      end
      if (!STANDBY_REQ) begin
         next_s.wake = 1'b0;
      end else if (s.stb && PINS.rxd_oe && !PINS.rxd) begin
         next_s.wake = 1'b1;
      end
      next_s.stb = STANDBY_REQ & ~next_s.wake;
      next_s.rx  = PINS.rxd_oe ? PINS.rxd : 1'b1;
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s     <= '0;
         s.txd <= 1'b1;
         s.rx  <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // tying STANDBY_REQ low keeps the transceiver in normal mode for good
   assign PINS.txd   = s.txd;
   assign PINS.stb   = s.stb;
   assign BIT_STROBE = s.strobe;
   assign RX_BIT     = s.rx;
   assign WAKE_SEEN  = s.wake;

endmodule : can_sic_ctrl
`default_nettype wire

/* tb/can_sic_checker.sv */
// checker for the logic pins and bus-side outputs of the transceiver end
// assumes one REF_CLK domain; instantiated by the bench beside the interface
`default_nettype none
module can_sic_checker #(
   parameter int DTO_CYCLES = 200
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic txd,
   input wire logic stb,
   input wire logic rxd,
   input wire logic rxd_oe,
   input wire logic LOGIC_SUPPLY_OK,
   input wire logic BUS_DOMINANT,
   input wire logic DRIVE_DOMINANT,
   input wire logic DRIVE_ACTIVE_REC,
   input wire logic BIAS_MID,
   input wire logic BIAS_GND,
   input wire logic DTO_FAULT,
   input wire logic WAKE_FLAG
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [17:0] low_cnt;
   logic [6:0]  act_cnt;
   logic        txd_q;

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   // low_cnt: normal-mode txd low samples; act_cnt: samples since a clean rising edge
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         low_cnt <= 18'h00000;
         act_cnt <= 7'h00;
         txd_q   <= 1'b1;
      end else begin
         txd_q   <= txd;
         low_cnt <= (!txd && !stb) ? low_cnt + 18'h00001 : 18'h00000;
         if (!txd || stb)
            act_cnt <= 7'h00;
         else if (!txd_q && !DTO_FAULT)
            act_cnt <= 7'h01;
         else if (act_cnt != 7'h00 && act_cnt != 7'h7F)
            act_cnt <= act_cnt + 7'h01;
      end
   end

   dom_map_a: assert property ($past(!txd && !stb) && !DTO_FAULT |-> DRIVE_DOMINANT)
      else $error("txd low gave no dominant drive");
   rx_mirror_a: assert property (!stb && !$past(stb) && rxd_oe |-> rxd == !$past(BUS_DOMINANT))
      else $error("rxd does not mirror the bus");
   dto_early_a: assert property (low_cnt != 0 && low_cnt < DTO_CYCLES - 1 |-> !DTO_FAULT)
      else $error("timeout fault too early");
   dto_trip_a: assert property (low_cnt == DTO_CYCLES + 3 |-> DTO_FAULT)
      else $error("timeout fault missing");
   dto_drive_a: assert property (DTO_FAULT |-> !DRIVE_DOMINANT)
      else $error("dominant drive during fault");
   dto_clear_a: assert property (DTO_FAULT && txd |-> ##[1:2] !DTO_FAULT)
      else $error("fault not cleared by recessive txd");
   act_hold_a: assert property (act_cnt >= 2 && act_cnt <= 52 |-> DRIVE_ACTIVE_REC)
      else $error("active recessive phase missing");
   pas_start_a: assert property (act_cnt == 67 |-> !DRIVE_ACTIVE_REC && BIAS_MID)
      else $error("passive recessive phase late");
   standby_bias_a: assert property (stb |=> BIAS_GND && !BIAS_MID && !DRIVE_DOMINANT && !DRIVE_ACTIVE_REC)
      else $error("standby bias or drive wrong");
   supply_gate_a: assert property (rxd_oe |-> $past(LOGIC_SUPPLY_OK))
      else $error("rxd driven without logic supply");
   wake_rxd_a: assert property (stb && $past(stb) && !rxd |-> ##[0:1] WAKE_FLAG)
      else $error("rxd low in standby without wake");
endmodule : can_sic_checker
`default_nettype wire

/* tb/can_sic_transceiver_control_bench.sv */
// bench: controller end and transceiver end joined by the logic-pin interface
// assumes the hw package, interface and both ends compiled first
`default_nettype none
module can_sic_transceiver_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DOMINANT_TIMEOUT = 200;
   logic ref_clk     = 1'b0;
   logic rst_n       = 1'b0;
   logic supply_ok   = 1'b0;
   logic tx_bit      = 1'b1;
   logic standby_req = 1'b0;
   logic bus_ext     = 1'b0;
   logic bus_dom, bit_strobe, rx_bit, wake_seen, drv_dom, drv_act, bias_mid, bias_gnd, dto_fault, wake_flag;
   int   num_errors  = 0;
   int   comparisons = 0;
   int   cycles      = 0;

   can_sic_if pins ();
   assign bus_dom = drv_dom | bus_ext;
   can_sic_ctrl #(.BIT_CYCLES(16), .DTO_CYCLES(DOMINANT_TIMEOUT)) i_can_sic_ctrl (.REF_CLK(ref_clk), .RST_N(rst_n),
      .PINS(pins), .TX_BIT(tx_bit), .STANDBY_REQ(standby_req), .BIT_STROBE(bit_strobe), .RX_BIT(rx_bit),
      .WAKE_SEEN(wake_seen));
   can_sic_xcvr #(.DTO_CYCLES(DOMINANT_TIMEOUT), .ACT_REC_CYCLES(53), .WAKE_FILT_CYCLES(4)) i_can_sic_xcvr (
      .REF_CLK(ref_clk), .RST_N(rst_n), .PINS(pins), .LOGIC_SUPPLY_OK(supply_ok), .BUS_DOMINANT(bus_dom),
      .DRIVE_DOMINANT(drv_dom), .DRIVE_ACTIVE_REC(drv_act), .BIAS_MID(bias_mid), .BIAS_GND(bias_gnd),
      .DTO_FAULT(dto_fault), .WAKE_FLAG(wake_flag));
   can_sic_checker #(.DTO_CYCLES(DOMINANT_TIMEOUT)) i_can_sic_checker (.REF_CLK(ref_clk), .RST_N(rst_n),
      .txd(pins.txd), .stb(pins.stb), .rxd(pins.rxd), .rxd_oe(pins.rxd_oe), .LOGIC_SUPPLY_OK(supply_ok),
      .BUS_DOMINANT(bus_dom), .DRIVE_DOMINANT(drv_dom), .DRIVE_ACTIVE_REC(drv_act), .BIAS_MID(bias_mid),
      .BIAS_GND(bias_gnd), .DTO_FAULT(dto_fault), .WAKE_FLAG(wake_flag));

   always #4 ref_clk = ~ref_clk;

   task automatic check(input logic seen, input logic exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc

   task automatic await_strobe();
      int k;
      k = 0;
      do begin
         @(negedge ref_clk);
         k++;
      end while (bit_strobe !== 1'b1 && k < 40);
      check(bit_strobe, 1'b1);
   endtask : await_strobe

   // put one bit on txd, then settle three cycles
   task automatic bit_out(input logic b);
      await_strobe();
      @(posedge ref_clk);
      tx_bit <= b;
      await_strobe();
      cyc(3);
   endtask : bit_out

   task automatic run_supply();
      cyc(4);
      check(pins.rxd_oe, 1'b0);
      check(rx_bit, 1'b1);
      @(posedge ref_clk);
      supply_ok <= 1'b1;
      cyc(3);
      check(pins.rxd_oe, 1'b1);
   endtask : run_supply

   // one bit time is 16 cycles, so eleven dominant bits end before the timeout
   task automatic run_rate();
      int n;
      await_strobe();
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (bit_strobe !== 1'b1 && n < 40);
      check(n == 16, 1'b1);
      check(11 * n < DOMINANT_TIMEOUT, 1'b1);
   endtask : run_rate

   task automatic run_map();
      check(pins.stb, 1'b0);
      bit_out(1'b0);
      check(drv_dom, 1'b1);
      check(rx_bit, 1'b0);
      bit_out(1'b1);
      check(drv_dom, 1'b0);
      check(drv_act, 1'b1);
      check(rx_bit, 1'b1);
      repeat (4) bit_out(1'b1);
      check(drv_act, 1'b0);
      check(bias_mid, 1'b1);
   endtask : run_map

   task automatic run_dto();
      repeat (9) bit_out(1'b0);
      check(dto_fault, 1'b1);
      check(drv_dom, 1'b0);
      @(posedge ref_clk);
      bus_ext <= 1'b1;
      cyc(3);
      check(rx_bit, 1'b0);
      @(posedge ref_clk);
      bus_ext <= 1'b0;
      cyc(3);
      check(rx_bit, 1'b1);
      bit_out(1'b1);
      check(dto_fault, 1'b0);
      check(drv_act, 1'b0);
      bit_out(1'b0);
      check(drv_dom, 1'b1);
      bit_out(1'b1);
   endtask : run_dto

   task automatic run_wake();
      int k;
      @(posedge ref_clk);
      standby_req <= 1'b1;
      tx_bit      <= 1'b0;
      cyc(4);
      check(pins.stb, 1'b1);
      check(bias_gnd, 1'b1);
      check(drv_dom, 1'b0);
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         bus_ext <= (i % 2 == 0);
         tx_bit  <= 1'b1;
         cyc(8);
         if (i < 3)
            check(pins.rxd, 1'b1);
      end
      k = 0;
      while (wake_seen !== 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      check(wake_seen, 1'b1);
      cyc(3);
      check(pins.stb, 1'b0);
      check(bias_mid, 1'b1);
      @(posedge ref_clk);
      standby_req <= 1'b0;
      cyc(3);
      check(wake_seen, 1'b0);
   endtask : run_wake

   task automatic close_out();
      $display("mismatches %0d of %0d comparisons", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      run_supply();
      run_rate();
      run_map();
      run_dto();
      run_wake();
      close_out();
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         close_out();
      end
   end
endmodule : can_sic_transceiver_control_bench
`default_nettype wire
